/* File: hdl/uart_full_half_duplex.sv */
// Full or half duplex asynchronous serial transceiver with register port.
// Assumes pin inputs synchronous to mclk_in; pads resolve pins from enables.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "uart_regs.svh"
module uart_full_half_duplex import uart_pkg::*; #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	// Register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Dedicated transmit pin
	output logic tx_pin_out,
	output logic tx_pin_oe_out,
	output logic tx_pullup_off_out,
	// Shared receive/transmit pin
	input wire logic rxtx_pin_in,
	output logic rxtx_pin_out,
	output logic rxtx_pin_oe_out,
	// Events
	output logic irq_out,
	output logic wake_req_out
);
	// ==========================================================
	// Elaboration check
	// Receive count register holds three bits
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 7) begin : g_bad_depth
		$error("FIFO_DEPTH must lie between 2 and 7");
	end

	// ==========================================================
	// Registers and decode
	logic [7:0] ctrl1_q, ctrl2_q, div_hi_q, div_lo_q, rdata_q;
	logic [1:0] ctrl3_q;
	logic [5:0] fmode_q;
	logic parity_error_flag_q, nf_q, framing_error_flag_q, overrun_error_flag_q, armed_q;
	wire wr_c1 = reg_wr_in & (reg_addr_in == `OFS_CTRL1);
	wire wr_c2 = reg_wr_in & (reg_addr_in == `OFS_CTRL2);
	wire wr_c3 = reg_wr_in & (reg_addr_in == `OFS_CTRL3);
	wire wr_hi = reg_wr_in & (reg_addr_in == `OFS_DIV_HI);
	wire wr_lo = reg_wr_in & (reg_addr_in == `OFS_DIV_LO);
	wire wr_fm = reg_wr_in & (reg_addr_in == `OFS_FMODE);
	wire wr_data = reg_wr_in & (reg_addr_in == `OFS_DATA);
	wire rd_data = reg_rd_in & (reg_addr_in == `OFS_DATA);
	wire rd_stat = reg_rd_in & (reg_addr_in == `OFS_STATUS);
	wire en = ctrl1_q[`C1_EN];
	wire data_length_select = ctrl1_q[`C1_BNO];
	wire parity_enable = ctrl1_q[`C1_PARITY_ENABLE];
	wire [1:0] prt = {ctrl1_q[`C1_PRT_HI], ctrl1_q[`C1_PRT_LO]};
	wire brk = ctrl1_q[`C1_BRK];
	wire single_wire_select = ctrl3_q[`C3_SWM];
	// Receiver has priority on the shared pin
	wire rx_on = en & ctrl2_q[`C2_RECEIVE_ENABLE];
	wire tx_run = en & ctrl2_q[`C2_TRANSMIT_ENABLE] & ~(single_wire_select & ctrl2_q[`C2_RECEIVE_ENABLE]);
	wire [15:0] divisor = {div_hi_q, div_lo_q};
	// Flags clear on data access after a status read
	wire flag_clr = (rd_data | wr_data) & armed_q;

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			ctrl1_q <= `CTRL_RST;
			ctrl2_q <= `CTRL_RST;
			ctrl3_q <= '0;
			fmode_q <= '0;
			div_hi_q <= `CTRL_RST;
			div_lo_q <= `CTRL_RST;
		end else begin
			if (wr_c1) ctrl1_q <= reg_wdata_in & ~(8'h01 << `C1_RX8);
			else if (!en) ctrl1_q[`C1_BRK] <= 1'b0;
			if (wr_c2) ctrl2_q <= reg_wdata_in;
			else if (!en) ctrl2_q[`C2_TRANSMIT_ENABLE:`C2_RECEIVE_ENABLE] <= 2'b00;
			if (wr_c3) ctrl3_q <= reg_wdata_in[1:0];
			if (wr_fm) fmode_q <= reg_wdata_in[5:0];
			if (wr_hi) div_hi_q <= reg_wdata_in;
			if (wr_lo) div_lo_q <= reg_wdata_in;
		end
	end

	// ==========================================================
	// Baud prescaler: one tick per oversample slot
	logic [15:0] baud_cnt_q;
	wire tick = (baud_cnt_q == divisor);

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in || !en || tick) baud_cnt_q <= '0;
		else baud_cnt_q <= baud_cnt_q + 16'h0001;
	end

	function automatic logic par_bit(input logic [8:0] d, input logic nine,
		input logic [1:0] kind);
		logic x;
		x = nine ? ^d : ^d[7:0];
		case (parity_e'(kind))
			PAR_EVEN: par_bit = x;
			PAR_ODD: par_bit = ~x;
			PAR_MARK: par_bit = 1'b1;
			PAR_SPACE: par_bit = 1'b0;
			default: par_bit = x;
		endcase
	endfunction

	// ==========================================================
	// Transmitter
	tx_state_e tx_st_q;
	logic [8:0] tx_buf_q, tx_sh_q;
	logic tx_full_q, tx_par_q, tx_line_q;
	logic [3:0] tx_sub_q, tx_cnt_q;
	wire tx_end = tick & (tx_sub_q == `OVS_LAST);
	wire [3:0] last_bit = data_length_select ? 4'h8 : 4'h7;
	// Break holds off new characters; buffer waits for it
	wire tx_load = (tx_st_q == TX_IDLE) & tx_full_q & ~brk & tx_run;
	wire tx_idle = (tx_st_q == TX_IDLE) & ~tx_full_q & ~brk;
	logic tx_line_d;

	always_comb begin
		case (tx_st_q)
			TX_START: tx_line_d = 1'b0;
			TX_DATA: tx_line_d = tx_sh_q[0];
			TX_PAR: tx_line_d = tx_par_q;
			default: tx_line_d = 1'b1;
		endcase
		if (brk) tx_line_d = 1'b0;
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in || !en) begin
			tx_full_q <= 1'b0;
			tx_buf_q <= '0;
		end else if (wr_data && tx_run) begin
			tx_full_q <= 1'b1;
			tx_buf_q <= {ctrl1_q[`C1_TX8], reg_wdata_in};
		end else if (tx_load) begin
			tx_full_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in || !en) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= '0;
			tx_par_q <= 1'b0;
			tx_sub_q <= '0;
			tx_cnt_q <= '0;
		end else begin
			if (tick) tx_sub_q <= tx_sub_q + 4'h1;
			case (tx_st_q)
				TX_IDLE: if (tx_load) begin
					tx_st_q <= TX_START;
					tx_sh_q <= tx_buf_q;
					tx_par_q <= par_bit(tx_buf_q, data_length_select, prt);
					tx_sub_q <= '0;
				end
				TX_START: if (tx_end) begin
					tx_st_q <= TX_DATA;
					tx_cnt_q <= '0;
				end
				TX_DATA: if (tx_end) begin
					tx_sh_q <= {1'b0, tx_sh_q[8:1]};
					tx_cnt_q <= tx_cnt_q + 4'h1;
					if (tx_cnt_q == last_bit) begin
						tx_st_q <= parity_enable ? TX_PAR : TX_STOP;
						tx_cnt_q <= '0;
					end
				end
				TX_PAR: if (tx_end) tx_st_q <= TX_STOP;
				TX_STOP: if (tx_end) begin
					tx_cnt_q <= tx_cnt_q + 4'h1;
					if (tx_cnt_q == 4'h1) tx_st_q <= TX_IDLE;
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) tx_line_q <= 1'b1;
		else tx_line_q <= tx_line_d;
	end

	// ==========================================================
	// Receiver
	rx_state_e rx_st_q;
	logic [8:0] rx_sh_q;
	logic [2:0] smp_q;
	logic [3:0] rx_sub_q, rx_cnt_q;
	logic rx_prev_q, rx_nf_q, rx_pe_q, rx_fe_q;
	wire rx_line = rxtx_pin_in;
	wire rx_end = tick & (rx_sub_q == `OVS_LAST);
	wire smp_now = tick & ((rx_sub_q == `SMP_A) | (rx_sub_q == `SMP_B) |
		(rx_sub_q == `SMP_C));
	// Majority of three samples; disagreement counts as noise
	wire maj = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) |
		(smp_q[0] & smp_q[2]);
	wire noisy = ~(&smp_q) & (|smp_q);
	wire [8:0] rx_data = data_length_select ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
	wire rx_done = (rx_st_q == RX_STOP) & rx_end &
		(~ctrl2_q[`C2_STOP_BIT_COUNT] | (rx_cnt_q == 4'h1));
	wire addr_ok = ~ctrl2_q[`C2_ADDRESS_DETECT_ENABLE] | (data_length_select ? rx_data[8] : rx_data[7]);
	wire fifo_full, fifo_empty;
	wire [8:0] fifo_dout;
	wire [2:0] fifo_cnt;
	// Overrun inhibits further transfers until cleared
	wire rx_push = rx_done & addr_ok & ~fifo_full & ~overrun_error_flag_q;
	wire rx_ovr = rx_done & addr_ok & fifo_full;
	wire rx_nf_all = rx_nf_q | noisy;
	wire rx_fe_all = rx_fe_q | ~maj;

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			rx_prev_q <= 1'b1;
			smp_q <= 3'h7;
		end else begin
			rx_prev_q <= rx_line;
			if (smp_now) smp_q <= {smp_q[1:0], rx_line};
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in || !rx_on) begin
			rx_st_q <= RX_IDLE;
			rx_sh_q <= '0;
			rx_sub_q <= '0;
			rx_cnt_q <= '0;
			rx_nf_q <= 1'b0;
			rx_pe_q <= 1'b0;
			rx_fe_q <= 1'b0;
		end else begin
			if (tick) rx_sub_q <= rx_sub_q + 4'h1;
			case (rx_st_q)
				RX_IDLE: if (rx_prev_q && !rx_line) begin
					rx_st_q <= RX_START;
					rx_sub_q <= '0;
					rx_nf_q <= 1'b0;
					rx_pe_q <= 1'b0;
					rx_fe_q <= 1'b0;
				end
				RX_START: if (rx_end) begin
					// A high start bit was a glitch
					rx_st_q <= maj ? RX_IDLE : RX_DATA;
					rx_nf_q <= noisy;
					rx_cnt_q <= '0;
				end
				RX_DATA: if (rx_end) begin
					rx_sh_q <= {maj, rx_sh_q[8:1]};
					rx_nf_q <= rx_nf_all;
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_cnt_q == last_bit) begin
						rx_st_q <= parity_enable ? RX_PAR : RX_STOP;
						rx_cnt_q <= '0;
					end
				end
				RX_PAR: if (rx_end) begin
					rx_pe_q <= (maj != par_bit(rx_data, data_length_select, prt));
					rx_nf_q <= rx_nf_all;
					rx_st_q <= RX_STOP;
				end
				RX_STOP: if (rx_end) begin
					rx_fe_q <= rx_fe_all;
					rx_nf_q <= rx_nf_all;
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_done) rx_st_q <= RX_IDLE;
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	uart_rx_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH),
		.CW(3)
	) u_rx_fifo (
		.clk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.flush_in(~en),
		.push_in(rx_push),
		.din_in(rx_data),
		.pop_in(rd_data),
		.dout_out(fifo_dout),
		.count_out(fifo_cnt),
		.full_out(fifo_full),
		.empty_out(fifo_empty)
	);

	// ==========================================================
	// Status flags
	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge mclk_in) begin
		if (!rst_b_in || !en) begin
			parity_error_flag_q <= 1'b0;
			nf_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			overrun_error_flag_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			parity_error_flag_q <= (rx_push & rx_pe_q) | (parity_error_flag_q & ~flag_clr);
			nf_q <= (rx_push & rx_nf_all) | (nf_q & ~flag_clr);
			framing_error_flag_q <= (rx_push & rx_fe_all) | (framing_error_flag_q & ~flag_clr);
			overrun_error_flag_q <= rx_ovr | (overrun_error_flag_q & ~flag_clr);
			if (rd_stat) armed_q <= 1'b1;
			else if (rd_data || wr_data) armed_q <= 1'b0;
		end
	end

	wire [2:0] trig = {1'b0, fmode_q[`FM_FTR_HI], fmode_q[`FM_FTR_LO]} + 3'h1;
	wire receive_data_available = ~fifo_empty & (fifo_cnt >= trig);
	wire transmit_buffer_empty = ~tx_full_q;
	wire receiver_idle_flag = (rx_st_q == RX_IDLE);
	wire [7:0] status = {parity_error_flag_q, nf_q, framing_error_flag_q, overrun_error_flag_q, receiver_idle_flag, receive_data_available, tx_idle,
		transmit_buffer_empty};
	wire [7:0] ctrl1_rd = {ctrl1_q[7:2], fifo_dout[8] & ~fifo_empty,
		ctrl1_q[0]};
	logic [7:0] rd_mux;

	always_comb begin
		case (reg_addr_in)
			`OFS_STATUS: rd_mux = status;
			`OFS_CTRL1: rd_mux = ctrl1_rd;
			`OFS_CTRL2: rd_mux = ctrl2_q;
			`OFS_CTRL3: rd_mux = {6'h00, ctrl3_q};
			`OFS_DATA: rd_mux = fifo_dout[7:0];
			`OFS_DIV_HI: rd_mux = div_hi_q;
			`OFS_DIV_LO: rd_mux = div_lo_q;
			`OFS_FMODE: rd_mux = {2'h0, fmode_q};
			`OFS_RECEIVE_FIFO_COUNT: rd_mux = {5'h00, fifo_cnt};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) rdata_q <= 8'h00;
		else rdata_q <= reg_rd_in ? rd_mux : 8'h00;
	end

	// ==========================================================
	// Pins, interrupt and wake-up
	logic tx_oe_q, rxtx_oe_q, pu_off_q, irq_q, wake_q;
	wire irq_d = (ctrl2_q[`C2_RIE] & (receive_data_available | overrun_error_flag_q)) |
		(ctrl2_q[`C2_TX_IDLE_INTERRUPT_ENABLE] & tx_idle) | (ctrl2_q[`C2_TX_EMPTY_INTERRUPT_ENABLE] & transmit_buffer_empty);
	// Wake only on a fresh falling edge while the receiver rests
	wire wake_d = en & ctrl2_q[`C2_WAKE] & receiver_idle_flag & rx_prev_q & ~rx_line;

	always_ff @(posedge mclk_in) begin
		if (!rst_b_in) begin
			tx_oe_q <= 1'b0;
			rxtx_oe_q <= 1'b0;
			pu_off_q <= 1'b0;
			irq_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			tx_oe_q <= tx_run & (~single_wire_select | ctrl3_q[`C3_MIRROR]);
			rxtx_oe_q <= tx_run & single_wire_select;
			pu_off_q <= en & ctrl2_q[`C2_TRANSMIT_ENABLE];
			irq_q <= irq_d;
			wake_q <= wake_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign tx_pin_out = tx_line_q;
	assign rxtx_pin_out = tx_line_q;
	assign tx_pin_oe_out = tx_oe_q;
	assign rxtx_pin_oe_out = rxtx_oe_q;
	assign tx_pullup_off_out = pu_off_q;
	assign irq_out = irq_q;
	assign wake_req_out = wake_q;
endmodule // uart_full_half_duplex
`default_nettype wire

/* File: hdl/uart_regs.svh */
// Register map, bit positions and timing counts of the serial transceiver.
// Assumes an 8-bit register port with a 4-bit register index.
//
// Operation
// - Frames carry eight or nine data bits, chosen by software.
// - Parity is even, odd, mark, space, or absent.
// - Receiver takes one or two stop bits; transmitter always sends two.
// - Bit timing comes from a 16-bit prescaler built from two divisor bytes.
// - Receiver flags parity, framing, noise and overrun errors.
// - With address detect on, only characters whose last data bit is one count.
// - Receive FIFO of FIFO_DEPTH entries (2 to 7, four by default); one transmit character buffered ahead of shifter.
// - Transmitter and receiver enable separately; receive pin activity requests wake-up.
// - Interrupt from tx empty, tx idle, rx trigger level, overrun.
// - Transmit pull-up is disconnected while serial and transmit enables are set.
// - Clearing the serial or transmit enable floats both serial pins.
// - Single wire select gives half duplex on the shared pin.
// - Shared pin receives when receive enabled, else transmits when transmit enabled.
// - Both enables set in single wire mode: receiving wins.
// - In single wire mode transmit data may also drive the dedicated pin.
// - Written character moves to a hidden shifter, sent LSB first at baud rate.
// - Received bits shift in LSB first; full shifter moves into receive buffer.
// - One data address: writes feed transmitter, reads return received characters.
// - Disabling discards buffers, resets baud counter, clears enables, break, flags, count.
// - Data length select zero means 8-bit frames, one means 9-bit frames.
// - Error flags clear by status read followed by data register access.
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

// ==========================================================
// Register indices
`define OFS_STATUS 4'h0
`define OFS_CTRL1 4'h1
`define OFS_CTRL2 4'h2
`define OFS_CTRL3 4'h3
`define OFS_DATA 4'h4
`define OFS_DIV_HI 4'h5
`define OFS_DIV_LO 4'h6
`define OFS_FMODE 4'h7
`define OFS_RECEIVE_FIFO_COUNT 4'h8

// ==========================================================
// Bit positions
`define S_PARITY_ERROR_FLAG 7
`define S_NF 6
`define S_FRAMING_ERROR_FLAG 5
`define S_OVERRUN_ERROR_FLAG 4
`define S_RECEIVER_IDLE_FLAG 3
`define S_RECEIVE_DATA_AVAILABLE 2
`define S_TRANSMITTER_IDLE_FLAG 1
`define S_TRANSMIT_BUFFER_EMPTY 0
`define C1_EN 7
`define C1_BNO 6
`define C1_PARITY_ENABLE 5
`define C1_PRT_HI 4
`define C1_PRT_LO 3
`define C1_BRK 2
`define C1_RX8 1
`define C1_TX8 0
`define C2_TRANSMIT_ENABLE 7
`define C2_RECEIVE_ENABLE 6
`define C2_STOP_BIT_COUNT 5
`define C2_ADDRESS_DETECT_ENABLE 4
`define C2_WAKE 3
`define C2_RIE 2
`define C2_TX_IDLE_INTERRUPT_ENABLE 1
`define C2_TX_EMPTY_INTERRUPT_ENABLE 0
`define C3_SWM 0
`define C3_MIRROR 1
`define FM_FTR_HI 1
`define FM_FTR_LO 0

// ==========================================================
// Reset values and oversampling points
`define CTRL_RST 8'h00
`define OVS_LAST 4'hf
`define SMP_A 4'h7
`define SMP_B 4'h8
`define SMP_C 4'h9

`endif

/* File: hdl/uart_pkg.sv */
// Types shared by the serial transceiver files.
// Assumes nothing of its surroundings.
package uart_pkg;
	typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_MARK, PAR_SPACE} parity_e;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
endpackage

/* File: hdl/uart_rx_fifo.sv */
// Receive character FIFO of the serial transceiver.
// Assumes one clock; push on full and pop on empty are ignored.
`timescale 1ns/100ps
`default_nettype none
module uart_rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4,
	parameter int CW = 3
) (
	// Clock and control
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic flush_in,
	// Write side
	input wire logic push_in,
	input wire logic [WIDTH-1:0] din_in,
	// Read side
	input wire logic pop_in,
	output logic [WIDTH-1:0] dout_out,
	output logic [CW-1:0] count_out,
	output logic full_out,
	output logic empty_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q, rd_ptr_q;
	logic [CW-1:0] cnt_q;
	wire do_push = push_in & ~full_out;
	wire do_pop = pop_in & ~empty_out;
	wire [AW-1:0] wr_next = (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
	wire [AW-1:0] rd_next = (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;

	assign full_out = (cnt_q == CW'(DEPTH));
	assign empty_out = (cnt_q == '0);
	assign count_out = cnt_q;
	assign dout_out = mem_q[rd_ptr_q];

	always_ff @(posedge clk_in) begin
		if (do_push) begin
			mem_q[wr_ptr_q] <= din_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in || flush_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) wr_ptr_q <= wr_next;
			if (do_pop) rd_ptr_q <= rd_next;
			if (do_push && !do_pop) cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push) cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // uart_rx_fifo
`default_nettype wire

/* File: dv/uart_partner.sv */
// Behavioural far-side serial device: sends and captures frames.
// Assumes a line idling high and a bit period of BIT_CLKS clocks.
`timescale 1ns/100ps
`default_nettype none
module uart_partner #(
	parameter int BIT_CLKS = 32
) (
	// Clock
	input wire logic clk_in,
	// Serial lines
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;

	// ==========================================================
	// Frame out: start, then bits LSB first, then idle high
	task automatic send(input logic [11:0] bits, input int n);
		line_out <= 1'b0;
		repeat (BIT_CLKS) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			line_out <= bits[i];
			repeat (BIT_CLKS) @(posedge clk_in);
		end
		// Idle gap lets the receiver leave its stop slot before a new start
		line_out <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk_in);
	endtask

	// ==========================================================
	// Frame in: mid-bit sampling; unknown result if no start seen
	task automatic recv(input int n, output logic [11:0] v);
		int k;
		v = 'x;
		k = 0;
		while (line_in !== 1'b0 && k < 4000) begin
			@(negedge clk_in);
			k++;
		end
		if (line_in === 1'b0) begin
			v = '0;
			repeat (BIT_CLKS / 2) @(negedge clk_in);
			for (int i = 0; i < n; i++) begin
				repeat (BIT_CLKS) @(negedge clk_in);
				v[i] = line_in;
			end
		end
	endtask
endmodule // uart_partner
`default_nettype wire

/* File: dv/uart_full_half_duplex_asserts.sv */
// Port-level checker of the serial transceiver.
// Assumes binding to the top module; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module uart_full_half_duplex_asserts #(
	parameter int FIFO_DEPTH = 4
) (
	// Clock, reset, register port
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// Pins and events
	input wire logic tx_pin_out,
	input wire logic tx_pin_oe_out,
	input wire logic tx_pullup_off_out,
	input wire logic rxtx_pin_in,
	input wire logic rxtx_pin_out,
	input wire logic rxtx_pin_oe_out,
	input wire logic irq_out,
	input wire logic wake_req_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);

	// ==========================================================
	// Properties
	property p_rdata_idle;
		!reg_rd_in |=> reg_rdata_out == 8'h00;
	endproperty
	property p_unmapped;
		reg_rd_in && reg_addr_in > 4'h8 |=> reg_rdata_out == 8'h00;
	endproperty
	property p_mirror;
		rxtx_pin_out == tx_pin_out;
	endproperty
	property p_swm_drive;
		rxtx_pin_oe_out |-> tx_pullup_off_out;
	endproperty
	property p_tx_drive;
		tx_pin_oe_out |-> tx_pullup_off_out;
	endproperty
	property p_wake_pulse;
		wake_req_out |=> !wake_req_out;
	endproperty
	// Shortest start bit is 16 clocks, at divisor zero
	property p_start_len;
		$fell(tx_pin_out) |-> !tx_pin_out [*8];
	endproperty
	property p_oe_idle;
		$rose(tx_pin_oe_out) |-> tx_pin_out;
	endproperty

	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside read cycle");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped index read not zero");
	a_mirror: assert property (p_mirror)
		else $error("shared pin data differs from transmit data");
	a_swm_drive: assert property (p_swm_drive)
		else $error("shared pin driven without transmitter on");
	a_tx_drive: assert property (p_tx_drive)
		else $error("transmit pin driven with pull-up attached");
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake request longer than one cycle");
	a_start_len: assert property (p_start_len)
		else $error("start bit too short");
	a_oe_idle: assert property (p_oe_idle)
		else $error("transmit pin not idle high when enabled");

	c_swm: cover property ($rose(rxtx_pin_oe_out));
	c_wake: cover property (wake_req_out);
	c_irq: cover property ($rose(irq_out));
endmodule // uart_full_half_duplex_asserts

bind uart_full_half_duplex uart_full_half_duplex_asserts #(
	.FIFO_DEPTH(FIFO_DEPTH)
) u_chk (
	.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
	.tx_pullup_off_out(tx_pullup_off_out), .rxtx_pin_in(rxtx_pin_in),
	.rxtx_pin_out(rxtx_pin_out), .rxtx_pin_oe_out(rxtx_pin_oe_out),
	.irq_out(irq_out), .wake_req_out(wake_req_out)
);
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the serial transceiver.
// Assumes divisor 1 (32 clocks a bit) and pulled-up idle pins.
`timescale 1ns/100ps
`default_nettype none
`include "uart_regs.svh"
module tb;
	localparam int BIT_CLKS = 32;
	logic mclk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic tx_pin, tx_oe, tx_pu_off, rxtx_out, rxtx_oe, irq, wake, peer_line;
	int n_fail = 0;
	int n_checks = 0;
	int n_wake = 0;
	// Released dedicated pin sits at its pull-up level; released shared pin follows the partner line
	wire logic tx_wire = tx_oe ? tx_pin : 1'b1;
	wire logic rxtx_wire = rxtx_oe ? rxtx_out : peer_line;

	always #2 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (wake === 1'b1) n_wake <= n_wake + 1;

	uart_full_half_duplex #(.FIFO_DEPTH(4)) u_dut (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .tx_pin_out(tx_pin), .tx_pin_oe_out(tx_oe),
		.tx_pullup_off_out(tx_pu_off), .rxtx_pin_in(rxtx_wire),
		.rxtx_pin_out(rxtx_out), .rxtx_pin_oe_out(rxtx_oe),
		.irq_out(irq), .wake_req_out(wake)
	);
	uart_partner #(.BIT_CLKS(BIT_CLKS)) u_peer (
		.clk_in(mclk_in), .line_in(tx_wire), .line_out(peer_line)
	);

	// ==========================================================
	// Access and compare tasks
	task automatic chk(input string what, input logic [11:0] e,
			input logic [11:0] got);
		n_checks++;
		if (got !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, e, got);
		end
	endtask
	task automatic wrr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] m,
			input logic [7:0] e, input string what);
		logic [7:0] v;
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#1 v = rdata;
		chk(what, {4'h0, e}, {4'h0, v & m});
		@(posedge mclk_in);
	endtask
	task automatic xmit(input logic [7:0] d, input logic [11:0] e,
			input int n, input string what);
		logic [11:0] v;
		wrr(`OFS_DATA, d);
		u_peer.recv(n, v);
		chk(what, e, v);
		repeat (BIT_CLKS) @(posedge mclk_in);
	endtask
	task automatic summarize;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge mclk_in);
		n_fail++;
		summarize;
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		@(posedge mclk_in);
		rdc(`OFS_STATUS, 8'hff, 8'h0b, "status");
		rdc(4'h9, 8'hff, 8'h00, "unmapped");
		wrr(`OFS_CTRL1, 8'h80);
		wrr(`OFS_DIV_LO, 8'h01);
		wrr(`OFS_CTRL2, 8'hc9);
		rdc(`OFS_DIV_LO, 8'hff, 8'h01, "div_lo");
		rdc(`OFS_DIV_HI, 8'hff, 8'h00, "div_hi");
		#1 chk("pins", 12'h007, {9'h0, tx_oe, tx_pu_off, irq});
		$display("test setup done");
		for (int p = 0; p < 4; p++) begin
			wrr(`OFS_CTRL1, 8'ha0 | 8'(p << 3));
			xmit(8'h07, {2'b11, ~p[0], 8'h07}, 11, "tx parity");
		end
		wrr(`OFS_CTRL1, 8'hc1);
		xmit(8'h5a, {2'b11, 1'b1, 8'h5a}, 11, "tx nine");
		$display("test transmit done");
		wrr(`OFS_CTRL1, 8'h80);
		u_peer.send({1'b1, 8'h3c}, 9);
		repeat (8) @(posedge mclk_in);
		rdc(`OFS_STATUS, 8'hff, 8'h0f, "status rx");
		rdc(`OFS_RECEIVE_FIFO_COUNT, 8'hff, 8'h01, "rx count");
		rdc(`OFS_DATA, 8'hff, 8'h3c, "rx data");
		wrr(`OFS_CTRL1, 8'he0);
		u_peer.send({1'b1, 1'b0, 9'h1a5}, 11);
		repeat (8) @(posedge mclk_in);
		rdc(`OFS_STATUS, 8'hff, 8'h8f, "status parity");
		rdc(`OFS_CTRL1, 8'h02, 8'h02, "rx ninth");
		rdc(`OFS_DATA, 8'hff, 8'ha5, "rx nine data");
		rdc(`OFS_STATUS, 8'hff, 8'h0b, "status clear");
		wrr(`OFS_CTRL1, 8'h80);
		u_peer.send({1'b0, 8'h11}, 9);
		repeat (8) @(posedge mclk_in);
		rdc(`OFS_STATUS, 8'hff, 8'h2f, "status framing");
		rdc(`OFS_DATA, 8'hff, 8'h11, "rx framed data");
		rdc(`OFS_STATUS, 8'hff, 8'h0b, "status clear");
		for (int i = 0; i < 5; i++) u_peer.send({1'b1, 8'(8'h40 + i)}, 9);
		repeat (8) @(posedge mclk_in);
		rdc(`OFS_RECEIVE_FIFO_COUNT, 8'hff, 8'h04, "fifo full count");
		rdc(`OFS_STATUS, 8'hff, 8'h1f, "status overrun");
		for (int i = 0; i < 4; i++) rdc(`OFS_DATA, 8'hff, 8'(8'h40 + i), "fifo");
		rdc(`OFS_STATUS, 8'hff, 8'h0b, "status drained");
		chk("wake seen", 12'h001, {11'h0, n_wake > 0});
		$display("test receive done");
		wrr(`OFS_CTRL3, 8'h03);
		wrr(`OFS_CTRL2, 8'h80);
		#1 chk("swm tx pins", 12'h007, {9'h0, rxtx_oe, tx_oe, tx_pu_off});
		xmit(8'h96, {2'b11, 8'h96}, 10, "swm data");
		wrr(`OFS_CTRL2, 8'hc0);
		#1 chk("swm rx pin", 12'h000, {11'h0, rxtx_oe});
		wrr(`OFS_CTRL1, 8'h00);
		#1 chk("off pins", 12'h000, {10'h0, rxtx_oe, tx_oe});
		rdc(`OFS_STATUS, 8'hff, 8'h0b, "status off");
		rdc(`OFS_CTRL2, 8'hc0, 8'h00, "enables off");
		$display("test single wire done");
		summarize;
	end
endmodule // tb
`default_nettype wire
